// file: rtl/vic_ctrl.sv
// Purpose: Ten-source, two-level vectored interrupt controller.
// Assumes: Core and peripherals are synchronous to i_clk_sys; the core
//          follows this block's machine-cycle phase (o_mcycle_end).
// Notes:   Registers reached over a plain byte port; read data next cycle.
`timescale 1ns/1ps
`default_nettype none
`include "vic_map.svh"

// Functional notes
// - Each serial port requests on receive-complete OR transmit-complete.
// - Both serial ports behave alike; second port controls at bit 4.
// - Priority bit 0 means low level, 1 means high level.
// - High may preempt low; nothing preempts a running high routine.
// - With both levels pending, the high request is served first.
// - Within a level, fixed polling order from ext_irq0 down to timer 2.
// - Each source has its enable; global_enable clear blocks every call.
// - Main enable bits: timer2 5, uart1 4, timer1 3, ext1 2, t0 1, ext0 0.
// - Secondary enable bits: display 7, uart2 4, two-wire 1, usb 0.
// - Main priority bits sit where the main enable bits sit.
// - Secondary priority bits: display 7, uart2 4, two-wire 1, usb 0.
// - Flags sampled at sample_phase, polled in the next machine cycle.
// - Call held off by busy level, non-final cycle, exit or enable/priority register access.
// - Blocked requests are forgotten; each poll uses fresh samples only.
// - Acknowledge is a long call to the source vector; status_word unsaved.
// - Fixed vector address per source.
// - Interrupt exit clears the current level's in-progress state.
// - Pin requests level or edge by trigger type; edge flag cleared on call.
// - Timer 0 and 1 flags cleared on service; timer 2 flag by software.
module vic_ctrl (
	// Clock and reset
	input  wire logic               i_clk_sys,
	input  wire logic               i_srst,
	// Register port
	input  wire logic [7:0]         i_reg_addr,
	input  wire logic [7:0]         i_reg_wdata,
	input  wire logic               i_reg_wr,
	input  wire logic               i_reg_rd,
	output logic [7:0]              o_reg_rdata,
	// Request sources
	input  wire vic_pkg::vic_flags_t i_flags,
	input  wire logic               i_ext_irq0_n,
	input  wire logic               i_ext_irq1_n,
	input  wire logic               i_ext_irq0_trigger_type,
	input  wire logic               i_ext_irq1_trigger_type,
	// Core status
	input  wire logic               i_last_cycle,
	input  wire logic               i_instr_block,
	input  wire logic               i_exit_instr,
	// Core call and hardware flag clears
	output logic                    o_mcycle_end,
	output logic                    o_call,
	output vic_pkg::vic_call_t      o_call_info,
	output logic                    o_timer0_clr,
	output logic                    o_timer1_clr,
	output logic [1:0]              o_level
);
	import vic_pkg::*;

	// Control registers
	logic [7:0]  enx_q;
	logic [7:0]  enm_q;
	logic [7:0]  prx_q;
	logic [7:0]  prm_q;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;

	// Machine cycle divider
	logic [3:0]  phase_q;
	logic        tick_sample;
	logic        tick_end;

	// External pin request state
	logic        pin0_prev_q;
	logic        pin1_prev_q;
	logic        edge0_q;
	logic        edge1_q;
	logic        fall0;
	logic        fall1;
	logic        req_x0;
	logic        req_x1;

	// Sampling and polling
	logic [9:0]  raw;
	logic [9:0]  smp_q;
	logic [9:0]  poll_q;
	logic [9:0]  src_en;
	logic [9:0]  src_prio;
	logic [9:0]  req;
	logic        blk_q;
	logic        blocked;
	logic        grant_valid;
	logic [3:0]  grant_idx;
	logic        grant_high;
	logic        call_go;

	// Level tracking and outputs
	vic_level_t  lvl_q;
	vic_level_t  lvl_d;
	logic        hi_busy;
	logic        lo_busy;
	logic [3:0]  last_src_q;
	logic        call_q;
	vic_call_t   info_q;
	logic        t0clr_q;
	logic        t1clr_q;
	logic        mend_q;
	logic        clr_x0;
	logic        clr_x1;

	// Register decode
	logic        wr_enx;
	logic        wr_enm;
	logic        wr_prx;
	logic        wr_prm;
	logic        reg_hit;

	assign wr_enx  = i_reg_wr & (i_reg_addr == `VIC_ADDR_ENX);
	assign wr_enm  = i_reg_wr & (i_reg_addr == `VIC_ADDR_ENM);
	assign wr_prx  = i_reg_wr & (i_reg_addr == `VIC_ADDR_PRX);
	assign wr_prm  = i_reg_wr & (i_reg_addr == `VIC_ADDR_PRM);
	// Any access to enable or priority holds off this poll
	assign reg_hit = (i_reg_wr | i_reg_rd) &
		((i_reg_addr == `VIC_ADDR_ENX) | (i_reg_addr == `VIC_ADDR_ENM) |
		(i_reg_addr == `VIC_ADDR_PRX) | (i_reg_addr == `VIC_ADDR_PRM));

	// Reserved and unused bits never store, so they read zero
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			enx_q <= `VIC_RST_REG;
			enm_q <= `VIC_RST_REG;
			prx_q <= `VIC_RST_REG;
			prm_q <= `VIC_RST_REG;
		end else begin
			if (wr_enx) begin
				enx_q <= i_reg_wdata & `VIC_MASK_ENX;
			end
			if (wr_enm) begin
				enm_q <= i_reg_wdata & `VIC_MASK_ENM;
			end
			if (wr_prx) begin
				prx_q <= i_reg_wdata & `VIC_MASK_PRX;
			end
			if (wr_prm) begin
				prm_q <= i_reg_wdata & `VIC_MASK_PRM;
			end
		end
	end

	// Read mux; status shows last source and the two busy levels
	always_comb begin
		case (i_reg_addr)
			`VIC_ADDR_ENX:  rdata_d = enx_q;
			`VIC_ADDR_ENM:  rdata_d = enm_q;
			`VIC_ADDR_PRX:  rdata_d = prx_q;
			`VIC_ADDR_PRM:  rdata_d = prm_q;
			`VIC_ADDR_STAT: rdata_d = {last_src_q, 2'b00, hi_busy, lo_busy};
			default:        rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			rdata_q <= 8'h00;
		end else if (i_reg_rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// Twelve-state machine cycle
	assign tick_sample = (phase_q == `VIC_PHASE_SAMPLE);
	assign tick_end    = (phase_q == `VIC_PHASE_LAST);

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			phase_q <= `VIC_PHASE_ZERO;
			mend_q  <= 1'b0;
		end else begin
			phase_q <= tick_end ? `VIC_PHASE_ZERO : phase_q + `VIC_PHASE_ONE;
			mend_q  <= tick_end;
		end
	end

	// Pins are active low; an edge request latches on a falling edge
	assign fall0  = pin0_prev_q & ~i_ext_irq0_n;
	assign fall1  = pin1_prev_q & ~i_ext_irq1_n;
	assign req_x0 = i_ext_irq0_trigger_type ? edge0_q : ~i_ext_irq0_n;
	assign req_x1 = i_ext_irq1_trigger_type ? edge1_q : ~i_ext_irq1_n;
	assign clr_x0 = call_go & (grant_idx == `VIC_SRC_X0);
	assign clr_x1 = call_go & (grant_idx == `VIC_SRC_X1);

	// A new edge in the clearing cycle wins over the clear
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			pin0_prev_q <= 1'b1;
			pin1_prev_q <= 1'b1;
			edge0_q     <= 1'b0;
			edge1_q     <= 1'b0;
		end else begin
			pin0_prev_q <= i_ext_irq0_n;
			pin1_prev_q <= i_ext_irq1_n;
			if (fall0) begin
				edge0_q <= 1'b1;
			end else if (clr_x0 | ~i_ext_irq0_trigger_type) begin
				edge0_q <= 1'b0;
			end
			if (fall1) begin
				edge1_q <= 1'b1;
			end else if (clr_x1 | ~i_ext_irq1_trigger_type) begin
				edge1_q <= 1'b0;
			end
		end
	end

	// Requests in polling order; serial ports OR their two flags
	assign raw[`VIC_SRC_X0]  = req_x0;
	assign raw[`VIC_SRC_U2]  = i_flags.uart2_rx_flag | i_flags.uart2_tx_flag;
	assign raw[`VIC_SRC_T0]  = i_flags.timer0_ovf;
	assign raw[`VIC_SRC_TW]  = i_flags.two_wire;
	assign raw[`VIC_SRC_X1]  = req_x1;
	assign raw[`VIC_SRC_DDC] = i_flags.display_channel;
	assign raw[`VIC_SRC_T1]  = i_flags.timer1_ovf;
	assign raw[`VIC_SRC_USB] = i_flags.usb;
	assign raw[`VIC_SRC_U1]  = i_flags.uart1_rx_flag | i_flags.uart1_tx_flag;
	assign raw[`VIC_SRC_T2]  = i_flags.timer2_ovf | i_flags.timer2_ext_flag;

	// Per-source enables and priorities gathered into poll order
	assign src_en[`VIC_SRC_X0]  = enm_q[`VIC_BIT_X0];
	assign src_en[`VIC_SRC_U2]  = enx_q[`VIC_BIT_U2];
	assign src_en[`VIC_SRC_T0]  = enm_q[`VIC_BIT_T0];
	assign src_en[`VIC_SRC_TW]  = enx_q[`VIC_BIT_TW];
	assign src_en[`VIC_SRC_X1]  = enm_q[`VIC_BIT_X1];
	assign src_en[`VIC_SRC_DDC] = enx_q[`VIC_BIT_DDC];
	assign src_en[`VIC_SRC_T1]  = enm_q[`VIC_BIT_T1];
	assign src_en[`VIC_SRC_USB] = enx_q[`VIC_BIT_USB];
	assign src_en[`VIC_SRC_U1]  = enm_q[`VIC_BIT_U1];
	assign src_en[`VIC_SRC_T2]  = enm_q[`VIC_BIT_T2];

	assign src_prio[`VIC_SRC_X0]  = prm_q[`VIC_BIT_X0];
	assign src_prio[`VIC_SRC_U2]  = prx_q[`VIC_BIT_U2];
	assign src_prio[`VIC_SRC_T0]  = prm_q[`VIC_BIT_T0];
	assign src_prio[`VIC_SRC_TW]  = prx_q[`VIC_BIT_TW];
	assign src_prio[`VIC_SRC_X1]  = prm_q[`VIC_BIT_X1];
	assign src_prio[`VIC_SRC_DDC] = prx_q[`VIC_BIT_DDC];
	assign src_prio[`VIC_SRC_T1]  = prm_q[`VIC_BIT_T1];
	assign src_prio[`VIC_SRC_USB] = prx_q[`VIC_BIT_USB];
	assign src_prio[`VIC_SRC_U1]  = prm_q[`VIC_BIT_U1];
	assign src_prio[`VIC_SRC_T2]  = prm_q[`VIC_BIT_T2];

	// Sample at sample_phase, hand over at cycle end, poll one cycle later
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			smp_q  <= 10'h000;
			poll_q <= 10'h000;
		end else begin
			if (tick_sample) begin
				smp_q <= raw;
			end
			if (tick_end) begin
				poll_q <= smp_q;
			end
		end
	end

	// Remember a blocking access seen anywhere in this machine cycle
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			blk_q <= 1'b0;
		end else if (tick_end) begin
			blk_q <= 1'b0;
		end else if (reg_hit | i_instr_block | i_exit_instr) begin
			blk_q <= 1'b1;
		end
	end

	// No pending memory: a blocked poll is simply dropped
	assign req     = poll_q & src_en & {10{enm_q[`VIC_BIT_GE]}};
	assign hi_busy = lvl_q[1];
	assign lo_busy = lvl_q[0];
	assign blocked = blk_q | reg_hit | i_instr_block | i_exit_instr | ~i_last_cycle;
	assign call_go = tick_end & grant_valid & ~blocked;

	vic_poll u_poll (
		.i_req     (req),
		.i_prio    (src_prio),
		.i_hi_busy (hi_busy),
		.i_lo_busy (lo_busy),
		.o_valid   (grant_valid),
		.o_idx     (grant_idx),
		.o_high    (grant_high)
	);

	function automatic logic [15:0] vec_of(input logic [3:0] idx);
		case (idx)
			`VIC_SRC_X0:  vec_of = `VIC_VEC_X0;
			`VIC_SRC_U2:  vec_of = `VIC_VEC_U2;
			`VIC_SRC_T0:  vec_of = `VIC_VEC_T0;
			`VIC_SRC_TW:  vec_of = `VIC_VEC_TW;
			`VIC_SRC_X1:  vec_of = `VIC_VEC_X1;
			`VIC_SRC_DDC: vec_of = `VIC_VEC_DDC;
			`VIC_SRC_T1:  vec_of = `VIC_VEC_T1;
			`VIC_SRC_USB: vec_of = `VIC_VEC_USB;
			`VIC_SRC_U1:  vec_of = `VIC_VEC_U1;
			default:      vec_of = `VIC_VEC_T2;
		endcase
	endfunction

	// Exit closes the innermost level; a call opens its own level
	always_comb begin
		lvl_d = lvl_q;
		case (lvl_q)
			VIC_IDLE: begin
				if (call_go) begin
					lvl_d = grant_high ? VIC_HIGH : VIC_LOW;
				end
			end
			VIC_LOW: begin
				if (i_exit_instr) begin
					lvl_d = VIC_IDLE;
				end else if (call_go) begin
					lvl_d = VIC_BOTH;
				end
			end
			VIC_HIGH: begin
				if (i_exit_instr) begin
					lvl_d = VIC_IDLE;
				end
			end
			VIC_BOTH: begin
				if (i_exit_instr) begin
					lvl_d = VIC_LOW;
				end
			end
			default: lvl_d = VIC_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			lvl_q <= VIC_IDLE;
		end else begin
			lvl_q <= lvl_d;
		end
	end

	// The core pushes the program counter only; status_word is untouched
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			call_q     <= 1'b0;
			info_q     <= '0;
			t0clr_q    <= 1'b0;
			t1clr_q    <= 1'b0;
			last_src_q <= 4'h0;
		end else begin
			call_q  <= call_go;
			t0clr_q <= call_go & (grant_idx == `VIC_SRC_T0);
			t1clr_q <= call_go & (grant_idx == `VIC_SRC_T1);
			if (call_go) begin
				info_q.vector <= vec_of(grant_idx);
				info_q.src    <= grant_idx;
				info_q.high   <= grant_high;
				last_src_q    <= grant_idx;
			end
		end
	end

	assign o_reg_rdata  = rdata_q;
	assign o_mcycle_end = mend_q;
	assign o_call       = call_q;
	assign o_call_info  = info_q;
	assign o_timer0_clr = t0clr_q;
	assign o_timer1_clr = t1clr_q;
	assign o_level      = lvl_q;

endmodule
`default_nettype wire

// file: rtl/vic_map.svh
// Purpose: Register map, bit positions, vectors and timing of the
//          vectored interrupt controller.
// Assumes: Included by its bare name.
// Notes:   Definitions only.
`ifndef VIC_MAP_SVH
`define VIC_MAP_SVH

// Register offsets
`define VIC_ADDR_ENX      8'hA7
`define VIC_ADDR_ENM      8'hA8
`define VIC_ADDR_PRX      8'hB7
`define VIC_ADDR_PRM      8'hB8
`define VIC_ADDR_STAT     8'hC7

// Writable bits; the rest read as zero
`define VIC_MASK_ENX      8'h93
`define VIC_MASK_ENM      8'hBF
`define VIC_MASK_PRX      8'h93
`define VIC_MASK_PRM      8'h3F
`define VIC_RST_REG       8'h00

// Bit positions in the main registers
`define VIC_BIT_GE        7
`define VIC_BIT_T2        5
`define VIC_BIT_U1        4
`define VIC_BIT_T1        3
`define VIC_BIT_X1        2
`define VIC_BIT_T0        1
`define VIC_BIT_X0        0
// Bit positions in the secondary registers
`define VIC_BIT_DDC       7
`define VIC_BIT_U2        4
`define VIC_BIT_TW        1
`define VIC_BIT_USB       0

// Source indices, also the polling order (0 first)
`define VIC_SRC_X0        4'h0
`define VIC_SRC_U2        4'h1
`define VIC_SRC_T0        4'h2
`define VIC_SRC_TW        4'h3
`define VIC_SRC_X1        4'h4
`define VIC_SRC_DDC       4'h5
`define VIC_SRC_T1        4'h6
`define VIC_SRC_USB       4'h7
`define VIC_SRC_U1        4'h8
`define VIC_SRC_T2        4'h9
`define VIC_NSRC          10

// Vector addresses
`define VIC_VEC_X0        16'h0003
`define VIC_VEC_T0        16'h000B
`define VIC_VEC_X1        16'h0013
`define VIC_VEC_T1        16'h001B
`define VIC_VEC_U1        16'h0023
`define VIC_VEC_T2        16'h002B
`define VIC_VEC_USB       16'h0033
`define VIC_VEC_DDC       16'h003B
`define VIC_VEC_TW        16'h0043
`define VIC_VEC_U2        16'h004B

// Machine cycle: twelve clock states, sample_phase is state 9
`define VIC_PHASE_LAST    4'hB
`define VIC_PHASE_SAMPLE  4'h9
`define VIC_PHASE_ZERO    4'h0
`define VIC_PHASE_ONE     4'h1

`endif

// file: rtl/vic_pkg.sv
// Purpose: Types shared by the interrupt controller files.
// Assumes: Nothing.
// Notes:   Constants live in vic_map.svh.
package vic_pkg;

	// Raw request flags from the peripherals, all active high
	typedef struct packed {
		logic timer2_ovf;
		logic timer2_ext_flag;
		logic uart1_rx_flag;
		logic uart1_tx_flag;
		logic usb;
		logic timer1_ovf;
		logic display_channel;
		logic two_wire;
		logic timer0_ovf;
		logic uart2_rx_flag;
		logic uart2_tx_flag;
	} vic_flags_t;

	// Hardware call handed to the core
	typedef struct packed {
		logic [15:0] vector;
		logic [3:0]  src;
		logic        high;
	} vic_call_t;

	// In-progress levels; BOTH means high nested inside low
	typedef enum logic [1:0] {
		VIC_IDLE = 2'b00,
		VIC_LOW  = 2'b01,
		VIC_HIGH = 2'b10,
		VIC_BOTH = 2'b11
	} vic_level_t;

endpackage

// file: rtl/vic_poll.sv
// Purpose: Picks one pending request by level, then by polling order.
// Assumes: Requests are already gated by enables.
// Notes:   Purely combinational; the caller registers the outcome.
`timescale 1ns/1ps
`default_nettype none
`include "vic_map.svh"

module vic_poll (
	// Requests and levels
	input  wire logic [9:0] i_req,
	input  wire logic [9:0] i_prio,
	// In-progress state
	input  wire logic       i_hi_busy,
	input  wire logic       i_lo_busy,
	// Outcome
	output logic            o_valid,
	output logic [3:0]      o_idx,
	output logic            o_high
);

	logic [9:0] hi_req;
	logic [9:0] lo_req;
	logic [9:0] pick;
	logic [3:0] idx;
	logic       hi_ok;
	logic       lo_ok;

	assign hi_req = i_req & i_prio;
	assign lo_req = i_req & ~i_prio;
	// High waits only for high; low waits for either level
	assign hi_ok  = (|hi_req) & ~i_hi_busy;
	assign lo_ok  = (|lo_req) & ~i_hi_busy & ~i_lo_busy;
	assign pick   = hi_ok ? hi_req : lo_req;

	// Lowest index wins, so scan from the far end down
	always_comb begin
		idx = 4'h0;
		for (int k = `VIC_NSRC - 1; k >= 0; k--) begin
			if (pick[k]) begin
				idx = 4'(k);
			end
		end
	end

	assign o_valid = hi_ok | lo_ok;
	assign o_idx   = idx;
	assign o_high  = hi_ok;

endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the vectored interrupt controller.
// Assumes: Core model and bound checker compiled alongside.
// Notes:   Pins run level-triggered except in the edge case.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import vic_pkg::*;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	vic_flags_t  flags = '0;
	logic        x0_n = 1'b1;
	logic        x1_n = 1'b1;
	logic        trig = 1'b0;
	logic        stall = 1'b0;
	logic        slow = 1'b0;
	logic        blk = 1'b0;
	logic        ret_req = 1'b0;
	logic        last_cycle, instr_block, exit_instr, mcyc, call, t0c, t1c;
	logic [7:0]  rdata;
	vic_call_t   info;
	logic [1:0]  level;
	int          error_cnt = 0;
	int          compares = 0;
	logic [9:0]  en, pr, pd;
	logic [2:0]  sel;
	logic        ge;
	logic [3:0]  e;
	localparam logic [15:0] VEC [10] = '{16'h0003, 16'h004B, 16'h000B, 16'h0043, 16'h0013,
		16'h003B, 16'h001B, 16'h0033, 16'h0023, 16'h002B};
	localparam logic [7:0] RA [4] = '{8'hA7, 8'hA8, 8'hB7, 8'hB8};
	localparam logic [7:0] RM [4] = '{8'h93, 8'hBF, 8'h93, 8'h3F};

	vic_ctrl u_dut (.i_clk_sys(clk), .i_srst(srst), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_flags(flags), .i_ext_irq0_n(x0_n),
		.i_ext_irq1_n(x1_n), .i_ext_irq0_trigger_type(trig), .i_ext_irq1_trigger_type(trig),
		.i_last_cycle(last_cycle), .i_instr_block(instr_block), .i_exit_instr(exit_instr),
		.o_mcycle_end(mcyc), .o_call(call), .o_call_info(info), .o_timer0_clr(t0c),
		.o_timer1_clr(t1c), .o_level(level));
	vic_core_model u_core (.i_clk_sys(clk), .i_srst(srst), .i_mcycle_end(mcyc), .i_call(call),
		.i_slow(slow), .i_stall(stall), .i_block(blk), .i_ret_req(ret_req),
		.o_last_cycle(last_cycle), .o_instr_block(instr_block), .o_exit_instr(exit_instr));

	always #5 clk = ~clk;

	function automatic logic [7:0] main_of(input logic [9:0] v, input logic top);
		return {top, 1'b0, v[9], v[8], v[6], v[4], v[2], v[0]};
	endfunction
	function automatic logic [7:0] ext_of(input logic [9:0] v);
		return {v[5], 2'b00, v[1], 2'b00, v[3], v[7]};
	endfunction
	// Highest level first, then polling order; 4'hF means no call
	function automatic logic [3:0] pick(input logic [9:0] p, input logic [9:0] n,
		input logic [9:0] q, input logic g);
		for (int h = 1; h >= 0; h--)
			for (int i = 0; i < 10; i++)
				if (g && p[i] && n[i] && q[i] == h[0])
					return i[3:0];
		return 4'hF;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, d);
	endtask
	task automatic cfg(input logic [9:0] n, input logic [9:0] q, input logic g);
		wr_reg(8'hA7, ext_of(n));
		wr_reg(8'hA8, main_of(n, g));
		wr_reg(8'hB7, ext_of(q));
		wr_reg(8'hB8, main_of(q, 1'b0));
	endtask
	// Serial and timer 2 requests use one of their two flags, picked by a bit of s
	task automatic drive(input logic [9:0] p, input logic [2:0] s);
		@(posedge clk);
		flags <= vic_flags_t'({p[9] & ~s[2], p[9] & s[2], p[8] & ~s[1], p[8] & s[1], p[7],
			p[6], p[5], p[3], p[2], p[1] & ~s[0], p[1] & s[0]});
		x0_n <= ~p[0];
		x1_n <= ~p[4];
	endtask
	// Software clears its flags right after the call, as handlers must
	task automatic expect_call(input logic [3:0] x, input logic hi);
		int n;
		n = 0;
		#1;
		while (call !== 1'b1 && n < 80) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (x == 4'hF) begin
			chk(call, 1'b0);
			return;
		end
		if (n >= 80) begin
			chk(call, 1'b1);
			test_done();
		end
		chk(info.src, x);
		chk(info.vector, VEC[x]);
		chk(info.high, hi);
		chk({t1c, t0c}, {x == 4'h6, x == 4'h2});
		drive(10'h000, 3'b000);
	endtask
	task automatic ret_chk(input logic [1:0] lv);
		repeat (30) @(posedge clk);
		ret_req <= 1'b1;
		@(posedge clk);
		ret_req <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk(level, lv);
	endtask

	initial begin
		void'($urandom(83));
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 4; i++)
			rd_chk(RA[i], 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr_reg(RA[i], 8'hFF);
			rd_chk(RA[i], RM[i]);
		end
		wr_reg(8'h55, 8'hFF);
		rd_chk(8'h55, 8'h00);
		repeat (40) begin
			en = 10'($urandom);
			pr = 10'($urandom);
			pd = 10'($urandom);
			sel = 3'($urandom);
			ge = ($urandom % 4) != 0;
			slow <= 1'($urandom);
			cfg(en, pr, ge);
			drive(pd, sel);
			e = pick(pd, en, pr, ge);
			expect_call(e, e == 4'hF ? 1'b0 : pr[e]);
			if (e == 4'hF)
				drive(10'h000, 3'b000);
			else
				ret_chk(2'b00);
		end
		slow <= 1'b0;
		cfg(10'h085, 10'h081, 1'b1);
		drive(10'h004, 3'b000);
		expect_call(4'h2, 1'b0);
		#1 chk(level, 2'b01);
		drive(10'h001, 3'b000);
		expect_call(4'h0, 1'b1);
		#1 chk(level, 2'b11);
		drive(10'h080, 3'b000);
		expect_call(4'hF, 1'b0);
		ret_chk(2'b01);
		expect_call(4'h7, 1'b1);
		rd_chk(8'hC7, 8'h73);
		ret_chk(2'b01);
		ret_chk(2'b00);
		stall <= 1'b1;
		drive(10'h001, 3'b000);
		expect_call(4'hF, 1'b0);
		drive(10'h000, 3'b000);
		repeat (30) @(posedge clk);
		stall <= 1'b0;
		expect_call(4'hF, 1'b0);
		blk <= 1'b1;
		drive(10'h001, 3'b000);
		expect_call(4'hF, 1'b0);
		blk <= 1'b0;
		expect_call(4'h0, 1'b1);
		ret_chk(2'b00);
		trig <= 1'b1;
		drive(10'h001, 3'b000);
		expect_call(4'h0, 1'b1);
		drive(10'h001, 3'b000);
		ret_chk(2'b00);
		// The edge seen while busy is kept and served once the level is free
		expect_call(4'h0, 1'b1);
		ret_chk(2'b00);
		expect_call(4'hF, 1'b0);
		test_done();
	end
endmodule
`default_nettype wire

// file: tb/vic_core_model.sv
// Purpose: Behavioural core standing on the far side of the controller.
// Assumes: Bench raises i_ret_req for one cycle to end a service routine.
// Notes:   Slow mode makes every instruction two machine cycles long.
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
	// Clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_srst,
	// From the controller
	input  wire logic i_mcycle_end,
	input  wire logic i_call,
	// Bench controls
	input  wire logic i_slow,
	input  wire logic i_stall,
	input  wire logic i_block,
	input  wire logic i_ret_req,
	// To the controller
	output logic      o_last_cycle,
	output logic      o_instr_block,
	output logic      o_exit_instr
);
	logic       odd_q;
	logic [3:0] depth_q;
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			odd_q <= 1'b0;
			depth_q <= 4'h0;
			o_exit_instr <= 1'b0;
		end else begin
			if (i_mcycle_end)
				odd_q <= !odd_q;
			// A routine only ends through the exit instruction, never a plain return
			o_exit_instr <= i_ret_req && depth_q != 4'h0;
			if (i_call)
				depth_q <= depth_q + 4'h1;
			else if (o_exit_instr)
				depth_q <= depth_q - 4'h1;
		end
	end
	assign o_last_cycle = !i_stall && (!i_slow || odd_q);
	assign o_instr_block = i_block;
endmodule
`default_nettype wire

// file: tb/vic_ctrl_sva.sv
// Purpose: Port-level checker for the vectored interrupt controller.
// Assumes: Bound to every vic_ctrl instance.
// Notes:   Global enable is tracked from register writes seen at the port.
`timescale 1ns/1ps
`default_nettype none
`include "vic_map.svh"
module vic_ctrl_sva
	import vic_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_srst,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic [7:0] i_reg_wdata,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	input  wire logic [7:0] o_reg_rdata,
	input  wire logic       i_last_cycle,
	input  wire logic       i_exit_instr,
	input  wire logic       o_mcycle_end,
	input  wire logic       o_call,
	input  wire vic_call_t  o_call_info,
	input  wire logic       o_timer0_clr,
	input  wire logic       o_timer1_clr,
	input  wire logic [1:0] o_level
);
	localparam logic [15:0] VEC [10] = '{16'h0003, 16'h004B, 16'h000B, 16'h0043, 16'h0013,
		16'h003B, 16'h001B, 16'h0033, 16'h0023, 16'h002B};
	logic       ge_q;
	logic [7:0] rd_mask;
	assign rd_mask = (i_reg_addr == `VIC_ADDR_ENX || i_reg_addr == `VIC_ADDR_PRX) ? 8'h93 :
		(i_reg_addr == `VIC_ADDR_ENM) ? 8'hBF : (i_reg_addr == `VIC_ADDR_PRM) ? 8'h3F :
		(i_reg_addr == `VIC_ADDR_STAT) ? 8'hF3 : 8'h00;
	always_ff @(posedge i_clk_sys) begin
		if (i_srst)
			ge_q <= 1'b0;
		else if (i_reg_wr && i_reg_addr == `VIC_ADDR_ENM)
			ge_q <= i_reg_wdata[7];
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	call_on_edge_a: assert property (o_call |-> o_mcycle_end)
		else $error("call off the machine-cycle boundary");
	mcycle_len_a: assert property (o_mcycle_end |=> !o_mcycle_end [*8] ##1 !o_mcycle_end [*3] ##1 o_mcycle_end)
		else $error("machine cycle not twelve clocks");
	vector_map_a: assert property (o_call |-> o_call_info.vector == VEC[o_call_info.src])
		else $error("vector does not match source");
	global_gate_a: assert property (o_call |-> ge_q)
		else $error("call with global enable clear");
	last_cycle_a: assert property (o_call |-> $past(i_last_cycle))
		else $error("call outside final instruction cycle");
	no_preempt_a: assert property (o_call |-> ($past(o_level) & 2'b10) == 2'b00 && (o_call_info.high || $past(o_level) == 2'b00))
		else $error("call preempted an equal or higher level");
	level_set_a: assert property (o_call |-> o_level == ($past(o_level) | (o_call_info.high ? 2'b10 : 2'b01)))
		else $error("level not set by call");
	exit_drop_a: assert property (i_exit_instr |=> o_level == ($past(o_level) == 2'b11 ? 2'b01 : 2'b00))
		else $error("exit did not drop innermost level");
	timer0_clr_a: assert property ((o_call && o_call_info.src == `VIC_SRC_T0) == o_timer0_clr)
		else $error("timer 0 clear mismatch");
	timer1_clr_a: assert property ((o_call && o_call_info.src == `VIC_SRC_T1) == o_timer1_clr)
		else $error("timer 1 clear mismatch");
	rdata_mask_a: assert property (i_reg_rd |=> (o_reg_rdata & ~$past(rd_mask)) == 8'h00)
		else $error("reserved bits read nonzero");
	cover property (o_call && o_call_info.high);
	cover property (o_level == 2'b11);
	cover property (i_exit_instr ##1 o_level == 2'b01);
endmodule
bind vic_ctrl vic_ctrl_sva u_sva (.i_clk_sys, .i_srst, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
	.i_reg_rd, .o_reg_rdata, .i_last_cycle, .i_exit_instr, .o_mcycle_end, .o_call, .o_call_info,
	.o_timer0_clr, .o_timer1_clr, .o_level);
`default_nettype wire
